// ==== rtl/serial_channel_map.svh ====
// register offsets, reset values, field codes and timing figures
`ifndef SERIAL_CHANNEL_MAP_SVH
`define SERIAL_CHANNEL_MAP_SVH
`define SC_FRAME_OFS 8'h00
`define SC_USAGE_OFS 8'h04
`define SC_PROTO_OFS 8'h08
`define SC_CTRL_OFS 8'h0C
`define SC_TXDATA_OFS 8'h10
`define SC_RXDATA_OFS 8'h14
`define SC_STATUS_OFS 8'h18
`define SC_FRAME_RST 32'h68100010
`define SC_USAGE_RST 32'h00000000
`define SC_PROTO_RST 32'h00000000
// control bits
`define SC_CT_OPEN 0
`define SC_CT_RXEN 1
// status bits
`define SC_ST_RXV 0
`define SC_ST_TXRDY 1
`define SC_ST_BUSY 2
`define SC_ST_RXEN 3
`define SC_ST_HOST 4
`define SC_ST_USER 5
`define SC_ST_PERR 6
`define SC_ST_FERR 7
`define SC_ST_OVR 8
// field codes
`define SC_USE_USER 4'h0
`define SC_USE_HOST 4'h2
`define SC_PERMIT 4'h1
`define SC_HOST_CHAN 8'h02
`define SC_POL_FORCE 4'h0
`define SC_PAR_ODD 4'h1
`define SC_PAR_EVEN 4'h2
`define SC_DLEN_7 4'h7
`define SC_STOP_2 4'h2
`define SC_BOARD_1 4'h1
`define SC_BOARD_2 4'h2
// bit rates in bits per second, clock in hertz
`define SC_BAUD_0 9600
`define SC_BAUD_1 19200
`define SC_BAUD_2 38400
`define SC_BAUD_3 57600
`define SC_BAUD_4 76800
`define SC_BAUD_5 115200
`define SC_BAUD_6 230400
`define SC_CLK_HZ 200000000
`define SC_LAT_UNIT_MS 1
`endif

// ==== rtl/serial_channel_pkg.sv ====
// types shared by the serial channel design
package serial_channel_pkg;
	typedef struct packed {
		logic [3:0] baud;
		logic [3:0] dlen;
		logic [3:0] stop;
		logic [3:0] parity;
		logic [3:0] rsvd;
		logic [3:0] rx_policy;
		logic [3:0] board_ch;
		logic [3:0] slot;
	} frame_cfg_t;
	typedef struct packed {
		logic [19:0] rsvd;
		logic [7:0]  latency_ms;
		logic [3:0]  usage;
	} usage_cfg_t;
	typedef struct packed {
		logic [19:0] rsvd;
		logic [7:0]  auto_chan;
		logic [3:0]  permit;
	} proto_cfg_t;
	typedef enum logic [2:0] {
		LN_IDLE, LN_START, LN_DATA, LN_PARITY, LN_STOP
	} line_state_t;
endpackage

// ==== rtl/extension_serial_channel.sv ====
// serial channel with apb registers, tx fifo and rs-232c/rs-485 line
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_map.svh"
//
// Contract
// - baud code in frame bits 31:28 picks 9.6k to 230.4k bit rate
// - frame bits 27:24 give 7 or 8 data bits per character
// - frame bits 23:20 give one or two stop bits
// - frame bits 19:16 select none, odd or even parity
// - frame bits 15:12 are stored only, with no effect
// - policy 0 forces receiver on after tx (rs485), before tx (rs232)
// - policy 1 never forces the receiver on around a transmission
// - frame bits 7:4 route the channel to on-board line 1 or 2
// - frame bits 3:0 hold slot; zero disables the channel
// - usage bits 3:0 choose program byte i/o or host protocol
// - host protocol waits the configured milliseconds before replying
// - host protocol usage accepted only when permission select is 1
// - host protocol by priority in manual, configured channel in auto
// - program usage moves bytes only while opened, one channel
// - rs485 shares a differential pair, rs232 separate lines
// - permission select reads 0 unpermitted, 1 permitted

////////////////////////////////////////////////////////////////////////
module serial_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,       // core clock
	input  wire logic             resetn,    // sync reset, active low
	input  wire logic [WIDTH-1:0] in_data,   // word to store
	input  wire logic             in_valid,  // word offered
	output logic                  in_ready,  // room for a word
	output logic [WIDTH-1:0]      out_data,  // oldest word
	output logic                  out_valid, // fifo not empty
	input  wire logic             out_ready  // drain takes a word
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("serial_fifo: DEPTH must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp;
	logic [AW:0]      rp;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	// extra pointer bit tells full from empty
	assign in_ready  = ~((wp[AW] != rp[AW]) &&
		(wp[AW-1:0] == rp[AW-1:0]));
	assign out_valid = (wp != rp);
	assign out_data  = mem[rp[AW-1:0]];

	// pointer and storage update
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (push) begin
				mem[wp[AW-1:0]] <= in_data;
				wp <= wp + 1'b1;
			end
			if (pop)
				rp <= rp + 1'b1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
module extension_serial_channel #(
	parameter int CLK_HZ     = `SC_CLK_HZ,
	parameter int CYC_PER_MS = `SC_CLK_HZ / 1000 * `SC_LAT_UNIT_MS,
	parameter int TX_DEPTH   = 16
) (
	input  wire logic        clk,           // core clock, 200 MHz
	input  wire logic        resetn,        // sync reset, active low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [7:0]  paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic [31:0]      prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error
	input  wire logic        rs485_mode,    // card is rs-485 type
	input  wire logic        manual_operating_mode, // manual mode
	input  wire logic        higher_port_busy, // higher port serves
	output logic [1:0]       txd,           // rs232 transmit lines
	input  wire logic [1:0]  rxd,           // rs232 receive lines
	output logic [1:0]       diff_line_pos_out,  // pair a drive
	output logic [1:0]       diff_line_pos_oe_n, // pair a enable
	input  wire logic [1:0]  diff_line_pos_in,   // pair a level
	output logic [1:0]       diff_line_neg_out,  // pair b drive
	output logic [1:0]       diff_line_neg_oe_n, // pair b enable
	input  wire logic [1:0]  diff_line_neg_in    // pair b level
);
	localparam int PW = $clog2(CYC_PER_MS + 1);
	if (CLK_HZ / `SC_BAUD_0 > 65535 || CLK_HZ / `SC_BAUD_6 < 4 ||
		CYC_PER_MS < 1 || TX_DEPTH < 2) begin : g_chk
		$error("extension_serial_channel: bad timing parameters");
	end

	// bit period in clocks for a baud code; bad codes run at 9.6k
	function automatic logic [15:0] bit_len(input logic [3:0] code);
		case (code)
		4'h1: bit_len = 16'(CLK_HZ / `SC_BAUD_1);
		4'h2: bit_len = 16'(CLK_HZ / `SC_BAUD_2);
		4'h3: bit_len = 16'(CLK_HZ / `SC_BAUD_3);
		4'h4: bit_len = 16'(CLK_HZ / `SC_BAUD_4);
		4'h5: bit_len = 16'(CLK_HZ / `SC_BAUD_5);
		4'h6: bit_len = 16'(CLK_HZ / `SC_BAUD_6);
		default: bit_len = 16'(CLK_HZ / `SC_BAUD_0);
		endcase
	endfunction

	serial_channel_pkg::frame_cfg_t  frame;
	serial_channel_pkg::usage_cfg_t  usage;
	serial_channel_pkg::proto_cfg_t  proto;
	serial_channel_pkg::line_state_t tx_st;
	serial_channel_pkg::line_state_t rx_st;
	logic        open_q, rx_en, rx_valid, perr, ferr, ovr;
	logic [7:0]  rx_data, tx_sh, rx_sh;
	logic [15:0] tx_tmr, rx_tmr;
	logic [3:0]  tx_cnt, rx_cnt;
	logic        tx_line, tx_par, rx_par;
	logic [7:0]  lat_ms;
	logic [PW-1:0] lat_pre;
	logic        fifo_in_ready, fifo_out_valid;
	logic [7:0]  fifo_out_data;

	////////////////////////////////////////////////////////////////
	// frame format decode
	wire [15:0] bit_cyc  = bit_len(frame.baud);
	wire        seven    = frame.dlen == `SC_DLEN_7;
	wire [3:0]  last_bit = seven ? 4'h6 : 4'h7;
	wire        two_stop = frame.stop == `SC_STOP_2;
	wire        par_en   = frame.parity == `SC_PAR_ODD ||
		frame.parity == `SC_PAR_EVEN;
	wire        par_odd  = frame.parity == `SC_PAR_ODD;
	wire        force_on = frame.rx_policy == `SC_POL_FORCE;

	// channel routing and usage gating
	wire ch_en   = frame.slot != 4'h0 &&
		(frame.board_ch == `SC_BOARD_1 ||
		frame.board_ch == `SC_BOARD_2);
	wire ch_sel  = frame.board_ch == `SC_BOARD_2;
	wire host_ok = proto.permit == `SC_PERMIT;
	wire host_turn = manual_operating_mode ? ~higher_port_busy
		: proto.auto_chan == `SC_HOST_CHAN;
	wire host_act = ch_en && usage.usage == `SC_USE_HOST &&
		host_ok && host_turn;
	wire user_act = ch_en && usage.usage == `SC_USE_USER &&
		open_q;
	wire link_act = host_act | user_act;
	wire lat_clear = lat_ms == 8'h00;

	////////////////////////////////////////////////////////////////
	// apb decode; a full tx fifo stalls the write instead of losing it
	wire sel_frame = paddr == `SC_FRAME_OFS;
	wire sel_usage = paddr == `SC_USAGE_OFS;
	wire sel_proto = paddr == `SC_PROTO_OFS;
	wire sel_ctrl  = paddr == `SC_CTRL_OFS;
	wire sel_tx    = paddr == `SC_TXDATA_OFS;
	wire sel_rx    = paddr == `SC_RXDATA_OFS;
	wire sel_stat  = paddr == `SC_STATUS_OFS;
	wire mapped = sel_frame | sel_usage | sel_proto | sel_ctrl |
		sel_tx | sel_rx | sel_stat;
	wire acc      = psel & penable;
	wire tx_stall = pwrite & sel_tx & link_act & ~fifo_in_ready;
	wire done     = acc & pready;
	wire wr       = done & pwrite;
	wire rd       = done & ~pwrite;
	wire use_bad  = sel_usage &&
		pwdata[3:0] == `SC_USE_HOST && !host_ok;
	wire tx_drop  = sel_tx & ~link_act;
	wire push     = wr & sel_tx & link_act;
	wire pop_rx   = rd & sel_rx;
	wire [31:0] status = {23'h0, ovr, ferr, perr, user_act, host_act,
		rx_en, tx_st != serial_channel_pkg::LN_IDLE,
		fifo_in_ready, rx_valid};
	wire [31:0] rd_mux = sel_frame ? frame :
		sel_usage ? usage : sel_proto ? proto :
		sel_ctrl  ? {30'h0, rx_en, open_q} :
		sel_rx    ? {24'h0, rx_data} :
		sel_stat  ? status : 32'h00000000;

	assign pready  = ~tx_stall;
	assign pslverr = acc & (~mapped | (pwrite & (use_bad | tx_drop)));

	// read data is captured in the setup cycle
	always_ff @(posedge clk) begin
		if (!resetn)
			prdata <= 32'h00000000;
		else if (psel & ~penable)
			prdata <= rd_mux;
	end

	// configuration and control writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			frame  <= `SC_FRAME_RST;
			usage  <= `SC_USAGE_RST;
			proto  <= `SC_PROTO_RST;
			open_q <= 1'b0;
		end else if (wr) begin
			if (sel_frame)
				frame <= pwdata;       // reserved nibble kept
			if (sel_usage & ~use_bad)
				usage <= pwdata;
			if (sel_proto)
				proto <= pwdata;
			if (sel_ctrl)
				open_q <= pwdata[`SC_CT_OPEN];
		end
	end

	////////////////////////////////////////////////////////////////
	// transmit fifo: apb fills, the transmitter drains
	wire tx_go = tx_st == serial_channel_pkg::LN_IDLE &&
		fifo_out_valid && link_act && lat_clear;

	serial_fifo #(
		.WIDTH (8),
		.DEPTH (TX_DEPTH)
	) u_txq (
		.clk       (clk),
		.resetn    (resetn),
		.in_data   (pwdata[7:0]),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (tx_go)
	);

	////////////////////////////////////////////////////////////////
	// transmitter
	wire [7:0] tx_word = seven ? {1'b0, fifo_out_data[6:0]}
		: fifo_out_data;
	wire tx_tick = tx_tmr == 16'h0000;
	wire tx_done = tx_st == serial_channel_pkg::LN_STOP &&
		tx_tick && tx_cnt == 4'h0;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_st   <= serial_channel_pkg::LN_IDLE;
			tx_tmr  <= 16'h0000;
			tx_cnt  <= 4'h0;
			tx_sh   <= 8'h00;
			tx_par  <= 1'b0;
			tx_line <= 1'b1;
		end else begin
			tx_tmr <= tx_tick ? bit_cyc - 16'h0001
				: tx_tmr - 16'h0001;
			case (tx_st)
			serial_channel_pkg::LN_IDLE: begin
				tx_tmr <= bit_cyc - 16'h0001;
				if (tx_go) begin
					tx_st   <= serial_channel_pkg::LN_START;
					tx_sh   <= tx_word;
					tx_par  <= par_odd ? ~^tx_word : ^tx_word;
					tx_line <= 1'b0;
				end
			end
			serial_channel_pkg::LN_START: if (tx_tick) begin
				tx_st   <= serial_channel_pkg::LN_DATA;
				tx_cnt  <= last_bit;
				tx_line <= tx_sh[0];
				tx_sh   <= tx_sh >> 1;
			end
			serial_channel_pkg::LN_DATA: if (tx_tick) begin
				if (tx_cnt != 4'h0) begin
					tx_cnt  <= tx_cnt - 4'h1;
					tx_line <= tx_sh[0];
					tx_sh   <= tx_sh >> 1;
				end else if (par_en) begin
					tx_st   <= serial_channel_pkg::LN_PARITY;
					tx_line <= tx_par;
				end else begin
					tx_st   <= serial_channel_pkg::LN_STOP;
					tx_cnt  <= {3'b000, two_stop};
					tx_line <= 1'b1;
				end
			end
			serial_channel_pkg::LN_PARITY: if (tx_tick) begin
				tx_st   <= serial_channel_pkg::LN_STOP;
				tx_cnt  <= {3'b000, two_stop};
				tx_line <= 1'b1;
			end
			serial_channel_pkg::LN_STOP: if (tx_tick) begin
				if (tx_cnt == 4'h0)
					tx_st <= serial_channel_pkg::LN_IDLE;
				else
					tx_cnt <= tx_cnt - 4'h1;
			end
			default: tx_st <= serial_channel_pkg::LN_IDLE;
			endcase
		end
	end

	// line drivers per on-board channel; rs485 drives the pair only
	// while a character is on the wire, else it listens
	wire tx_busy = tx_st != serial_channel_pkg::LN_IDLE;
	for (genvar i = 0; i < 2; i++) begin : g_line
		wire on_ch = ch_en && (ch_sel == (i == 1));
		assign txd[i] = (on_ch & ~rs485_mode) ? tx_line : 1'b1;
		assign diff_line_pos_out[i]  = tx_line;
		assign diff_line_neg_out[i]  = ~tx_line;
		assign diff_line_pos_oe_n[i] = ~(on_ch & rs485_mode & tx_busy);
		assign diff_line_neg_oe_n[i] = ~(on_ch & rs485_mode & tx_busy);
	end

	////////////////////////////////////////////////////////////////
	// receiver enable: software level, forced on around transmission under policy 0
	wire rx_force = force_on &
		(rs485_mode ? tx_done : tx_go);

	always_ff @(posedge clk) begin
		if (!resetn)
			rx_en <= 1'b0;
		else if (rx_force)
			rx_en <= 1'b1;
		else if (wr & sel_ctrl)
			rx_en <= pwdata[`SC_CT_RXEN];
	end

	// half duplex gating keeps our own echo out of the receiver
	wire rx_raw  = rs485_mode ? diff_line_pos_in[ch_sel]
		: rxd[ch_sel];
	wire rx_ok   = rx_en & link_act & ~(rs485_mode & tx_busy);
	wire rx_line = rx_ok ? rx_raw : 1'b1;
	wire rx_tick = rx_tmr == 16'h0000;
	wire [7:0] rx_word = seven ? {1'b0, rx_sh[7:1]} : rx_sh;
	wire rx_exp  = par_odd ? ~^rx_word : ^rx_word;
	wire rx_done = rx_st == serial_channel_pkg::LN_STOP && rx_tick;

	// receiver samples mid bit after a half-bit start check
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_st  <= serial_channel_pkg::LN_IDLE;
			rx_tmr <= 16'h0000;
			rx_cnt <= 4'h0;
			rx_sh  <= 8'h00;
			rx_par <= 1'b0;
		end else begin
			rx_tmr <= rx_tick ? bit_cyc - 16'h0001
				: rx_tmr - 16'h0001;
			case (rx_st)
			serial_channel_pkg::LN_IDLE: begin
				rx_tmr <= (bit_cyc >> 1) - 16'h0001;
				if (!rx_line)
					rx_st <= serial_channel_pkg::LN_START;
			end
			serial_channel_pkg::LN_START: if (rx_tick) begin
				rx_st  <= rx_line ? serial_channel_pkg::LN_IDLE
					: serial_channel_pkg::LN_DATA;
				rx_cnt <= last_bit;
			end
			serial_channel_pkg::LN_DATA: if (rx_tick) begin
				rx_sh  <= {rx_line, rx_sh[7:1]};
				rx_cnt <= rx_cnt - 4'h1;
				if (rx_cnt == 4'h0)
					rx_st <= par_en ? serial_channel_pkg::LN_PARITY
						: serial_channel_pkg::LN_STOP;
			end
			serial_channel_pkg::LN_PARITY: if (rx_tick) begin
				rx_par <= rx_line;
				rx_st  <= serial_channel_pkg::LN_STOP;
			end
			serial_channel_pkg::LN_STOP: if (rx_tick)
				rx_st <= serial_channel_pkg::LN_IDLE;
			default: rx_st <= serial_channel_pkg::LN_IDLE;
			endcase
		end
	end

	// received byte and sticky flags; a new event beats a clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_data  <= 8'h00;
			rx_valid <= 1'b0;
			perr <= 1'b0;
			ferr <= 1'b0;
			ovr  <= 1'b0;
		end else begin
			if (pop_rx)
				rx_valid <= 1'b0;
			if (wr & sel_stat) begin
				perr <= perr & ~pwdata[`SC_ST_PERR];
				ferr <= ferr & ~pwdata[`SC_ST_FERR];
				ovr  <= ovr & ~pwdata[`SC_ST_OVR];
			end
			if (rx_done) begin
				rx_data  <= rx_word;
				rx_valid <= 1'b1;
				if (par_en && rx_par != rx_exp)
					perr <= 1'b1;
				if (!rx_line)
					ferr <= 1'b1;
				if (rx_valid & ~pop_rx)
					ovr <= 1'b1;
			end
		end
	end

	// reply latency: each byte received under host protocol restarts the wait
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lat_ms  <= 8'h00;
			lat_pre <= '0;
		end else if (rx_done & host_act) begin
			lat_ms  <= usage.latency_ms;
			lat_pre <= PW'(CYC_PER_MS - 1);
		end else if (!lat_clear) begin
			lat_pre <= (lat_pre == '0) ? PW'(CYC_PER_MS - 1)
				: lat_pre - 1'b1;
			if (lat_pre == '0)
				lat_ms <= lat_ms - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [15:0] start_len;
	always_ff @(posedge clk)
		start_len <= (tx_st == serial_channel_pkg::LN_START)
			? start_len + 16'h0001 : 16'h0000;

	// copy of the character taken from the fifo; the shifter has
	// emptied by the time the parity bit is on the wire
	logic [7:0] sent_word;
	always_ff @(posedge clk)
		if (tx_go)
			sent_word <= tx_word;

	a_start_bit_len: assert property (
		tx_st == serial_channel_pkg::LN_START ##1
		tx_st != serial_channel_pkg::LN_START |->
		$past(start_len) == bit_cyc - 16'h0001)
		else $error("start bit length differs from bit period");
	a_start_low: assert property (
		tx_st == serial_channel_pkg::LN_START |-> !tx_line)
		else $error("start bit not low");
	a_stop_high: assert property (
		tx_st == serial_channel_pkg::LN_STOP |-> tx_line)
		else $error("stop bit not high");
	a_parity_bit: assert property (
		tx_st == serial_channel_pkg::LN_PARITY |->
		tx_line == (par_odd ? ~^sent_word : ^sent_word))
		else $error("parity bit wrong");
	a_slot_off: assert property (
		frame.slot == 4'h0 |-> !link_act && txd == 2'b11 &&
		diff_line_pos_oe_n == 2'b11)
		else $error("disabled channel still active");
	a_host_perm: assert property (
		host_act |-> proto.permit == `SC_PERMIT &&
		(manual_operating_mode || proto.auto_chan == `SC_HOST_CHAN))
		else $error("host protocol served without permission");
	a_force_485: assert property (
		force_on && rs485_mode && tx_done |=> rx_en)
		else $error("receiver not forced on after send");
	a_force_232: assert property (
		force_on && !rs485_mode && tx_go |=> rx_en)
		else $error("receiver not forced on before send");
	a_no_force: assert property (
		!force_on && !rx_en && !(wr && sel_ctrl) |=> !rx_en)
		else $error("receiver forced on under policy 1");
	a_reply_wait: assert property (
		tx_go && usage.usage == `SC_USE_HOST |-> lat_ms == 8'h00)
		else $error("reply sent before latency expired");
	a_user_open: assert property (
		tx_go && !host_act |-> open_q)
		else $error("byte sent on unopened channel");
	a_half_duplex: assert property (
		rs485_mode && tx_busy |-> !rx_ok && txd == 2'b11)
		else $error("rs485 not half duplex");

	c_frame_sent: cover property (tx_done);
	c_byte_recv: cover property (rx_done && !perr);
	c_fifo_stall: cover property (acc && tx_stall);
	c_host_reply: cover property (host_act && tx_go);
endmodule
`default_nettype wire

// ==== sim/serial_peer.sv ====
// serial peer on the far side of the channel line
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module serial_peer (
	input  wire logic        clk,     // core clock
	input  wire logic        line,    // line from the channel
	input  wire logic [15:0] bit_cyc, // cycles per bit
	input  wire logic [3:0]  nbits,   // bits after the start bit
	output logic             rx       // line into the channel
);
	logic [15:0] frame;  // last character, first bit at lsb
	int          frames; // characters seen so far

	// sample mid bit after the start edge; a wrong period drifts out
	initial begin
		frames = 0;
		frame = '0;
		forever begin
			@(posedge clk);
			if (line === 1'b0) begin
				frame = '0;
				repeat (bit_cyc / 2) @(posedge clk);
				for (int i = 0; i < nbits; i++) begin
					repeat (bit_cyc) @(posedge clk);
					frame[i] = line;
				end
				frames++;
			end
		end
	end

	// idle high between characters
	initial rx = 1'b1;

	// one 8n1 character at a time, never two at once
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx <= f[i];
			repeat (bit_cyc) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the extension serial channel
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_map.svh"
////////////////////////////////////////////////////////////////////////
module tb;
	localparam int CHZ = 2304000; // ten cycles a bit at the top rate
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic        rs485, manual, hbusy, prx, ch, line, erv;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [1:0]  txd, pos_o, pos_oe_n, neg_o, neg_oe_n, pos_i, neg_i;
	logic [15:0] bcyc;
	logic [3:0]  nbits;
	int          err_count, checks_done;
	int          br[7] = '{`SC_BAUD_0, `SC_BAUD_1, `SC_BAUD_2,
		`SC_BAUD_3, `SC_BAUD_4, `SC_BAUD_5, `SC_BAUD_6};

	// pair level from whoever enables, else the peer
	assign pos_i = ~pos_oe_n & pos_o | pos_oe_n & {2{prx}};
	assign neg_i = ~neg_oe_n & neg_o | neg_oe_n & ~{2{prx}};
	assign line  = rs485 ? pos_o[ch] : txd[ch];

	extension_serial_channel #(.CLK_HZ(CHZ), .CYC_PER_MS(20))
		u_extension_serial_channel (.clk(clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rs485_mode(rs485),
		.manual_operating_mode(manual), .higher_port_busy(hbusy),
		.txd(txd), .rxd({2{prx}}), .diff_line_pos_out(pos_o),
		.diff_line_pos_oe_n(pos_oe_n), .diff_line_pos_in(pos_i),
		.diff_line_neg_out(neg_o), .diff_line_neg_oe_n(neg_oe_n),
		.diff_line_neg_in(neg_i));
	serial_peer u_serial_peer (.clk(clk), .line(line), .bit_cyc(bcyc),
		.nbits(nbits), .rx(prx));

	// clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] s, x);
		checks_done++;
		if (s !== x) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask

	task automatic results;
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// pready, prdata and pslverr are taken at the rising edge that ends
	// the access; a stalled write just waits, the watchdog bounds it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wfr(input int n);
		int f0;
		f0 = u_serial_peer.frames;
		for (int k = 0; k < n * 14 * bcyc; k++)
			if (u_serial_peer.frames < f0 + n) @(posedge clk);
		chk("frames_seen", u_serial_peer.frames >= f0 + n, 1'b1);
	endtask

	// expected line pattern worked out from the frame word
	task automatic xmit(input logic [31:0] fw, input logic [7:0] b);
		logic [15:0] e;
		int          n;
		n = (fw[27:24] == `SC_DLEN_7) ? 7 : 8;
		e = (n == 7) ? {9'h000, b[6:0]} : {8'h00, b};
		if (fw[19:16] == `SC_PAR_ODD || fw[19:16] == `SC_PAR_EVEN) begin
			e[n] = ^e ^ (fw[19:16] == `SC_PAR_ODD);
			n++;
		end
		e = e | ((fw[23:20] == `SC_STOP_2 ? 16'h0003 : 16'h0001) << n);
		nbits <= 4'(n + ((fw[23:20] == `SC_STOP_2) ? 2 : 1));
		bcyc <= 16'(CHZ / br[fw[31:28]]);
		ch <= (fw[7:4] == `SC_BOARD_2);
		apb(1'b1, `SC_FRAME_OFS, fw);
		apb(1'b1, `SC_TXDATA_OFS, {24'h000000, b});
		wfr(1);
		chk("frame", u_serial_peer.frame, e);
	endtask

	task automatic t_reset;
		apb(1'b0, `SC_FRAME_OFS, 0);
		chk("frame_rst", rdv, `SC_FRAME_RST);
		apb(1'b0, `SC_USAGE_OFS, 0);
		chk("usage_rst", rdv, `SC_USAGE_RST);
		apb(1'b0, 8'h1C, 0);
		chk("unmapped", erv, 1'b1);
		apb(1'b1, `SC_TXDATA_OFS, 8'h55);
		chk("slot_zero", erv, 1'b1);
		chk("txd_idle", txd, 2'b11);
	endtask

	task automatic t_frames;
		apb(1'b1, `SC_CTRL_OFS, 1);
		for (int c = 0; c < 7; c++)
			xmit({c[3:0], 28'h8100011}, 8'hA5);
		xmit(32'h6810F011, 8'hA5);
		apb(1'b0, `SC_FRAME_OFS, 0);
		chk("rsvd_kept", rdv, 32'h6810F011);
		xmit(32'h67220011, 8'hD3);
		xmit(32'h68110011, 8'h0F);
		xmit(32'h68220011, 8'h07);
		xmit(32'h68100021, 8'h5A);
		xmit(32'h68100011, 8'hC3);
	endtask

	// 17 words fill shifter and fifo, the 18th stalls until a pop
	task automatic t_fifo;
		int f0;
		f0 = u_serial_peer.frames;
		for (int i = 0; i < 18; i++) begin
			if (i == 17) apb(1'b0, `SC_STATUS_OFS, 0);
			if (i == 17) chk("full", rdv[`SC_ST_TXRDY], 1'b0);
			apb(1'b1, `SC_TXDATA_OFS, i);
		end
		chk("stall_err", erv, 1'b0);
		wfr(f0 + 18 - u_serial_peer.frames);
		chk("drained", u_serial_peer.frames - f0, 18);
		chk("last", u_serial_peer.frame, 16'h0111);
	endtask

	// rs232 policy 0, rs232 policy 1, rs485 policy 0
	task automatic t_policy;
		for (int k = 0; k < 3; k++) begin
			rs485 <= (k == 2);
			apb(1'b1, `SC_FRAME_OFS,
				(k == 1) ? 32'h68100111 : 32'h68100011);
			apb(1'b1, `SC_CTRL_OFS, 1);
			apb(1'b1, `SC_TXDATA_OFS, 8'hA5);
			repeat (30) @(negedge clk);
			chk("oe_n", pos_oe_n[0], k != 2);
			chk("neg_oe_n", neg_oe_n[0], k != 2);
			chk("pair", neg_o[0], !pos_o[0]);
			apb(1'b0, `SC_STATUS_OFS, 0);
			chk("rxen_mid", rdv[`SC_ST_RXEN], k == 0);
			wfr(1);
			repeat (10) @(posedge clk);
			apb(1'b0, `SC_STATUS_OFS, 0);
			chk("rxen_end", rdv[`SC_ST_RXEN], k != 1);
		end
		rs485 <= 1'b0;
	endtask

	task automatic t_rx;
		apb(1'b1, `SC_CTRL_OFS, 3);
		u_serial_peer.send(8'h3C);
		apb(1'b0, `SC_RXDATA_OFS, 0);
		chk("rx_byte", rdv[7:0], 8'h3C);
		apb(1'b1, `SC_FRAME_OFS, 32'h68120011);
		u_serial_peer.send(8'h3C);
		repeat (bcyc) @(posedge clk);
		apb(1'b0, `SC_STATUS_OFS, 0);
		chk("perr_set", rdv[`SC_ST_PERR], 1'b1);
		apb(1'b1, `SC_STATUS_OFS, 32'h00000040);
		apb(1'b0, `SC_STATUS_OFS, 0);
		chk("perr_clr", rdv[`SC_ST_PERR], 1'b0);
		apb(1'b1, `SC_FRAME_OFS, 32'h68100011);
		apb(1'b1, `SC_CTRL_OFS, 2);
		apb(1'b1, `SC_TXDATA_OFS, 8'h11);
		chk("closed", erv, 1'b1);
	endtask

	task automatic t_host;
		int n;
		rs485 <= 1'b1;
		apb(1'b1, `SC_USAGE_OFS, 2);
		chk("no_permit", erv, 1'b1);
		apb(1'b1, `SC_PROTO_OFS, 32'h21);
		apb(1'b1, `SC_USAGE_OFS, 32'h22);
		apb(1'b0, `SC_USAGE_OFS, 0);
		chk("usage_host", rdv, 32'h22);
		manual <= 1'b1;
		hbusy <= 1'b1;
		apb(1'b0, `SC_STATUS_OFS, 0);
		chk("manual_busy", rdv[`SC_ST_HOST], 1'b0);
		hbusy <= 1'b0;
		apb(1'b0, `SC_STATUS_OFS, 0);
		chk("manual_free", rdv[`SC_ST_HOST], 1'b1);
		u_serial_peer.send(8'h11);
		apb(1'b1, `SC_TXDATA_OFS, 8'h42);
		for (n = 0; n < 200 && line !== 1'b0; n++) @(posedge clk);
		chk("latency", n >= 25 && n < 60, 1'b1);
		wfr(1);
		chk("reply", u_serial_peer.frame, 16'h0142);
	endtask

	// watchdog: the whole run needs well under a third of this span
	initial begin
		#500000;
		err_count++;
		results;
	end

	initial begin
		{resetn, psel, penable, pwrite, rs485, manual, hbusy} = '0;
		{paddr, pwdata, ch} = '0;
		{bcyc, nbits} = {16'd10, 4'd9};
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		t_reset;
		t_frames;
		t_fifo;
		t_policy;
		t_rx;
		t_host;
		results;
	end
endmodule
`default_nettype wire
